/* inc/wake_pkg.sv */
// Purpose: Shared constants and types for the wake input and interrupt block.
// Assumes: 125 MHz system clock.
// Notes: Times are kept in their own unit and converted to cycle counts here.
`default_nettype none
package wake_pkg;
	// Clock period in picoseconds
	localparam int CLOCK_PERIOD_PS = 8000;
	// Wake filter time in microseconds, typical
	localparam int WAKE_FILTER_US = 16;
	// Interrupt pulse width in microseconds, typical
	localparam int IRQ_PULSE_US = 100;
	// Minimum interrupt gap in microseconds, typical
	localparam int IRQ_GAP_US = 100;
	// Cycle counts derived from the times above
	localparam int WAKE_FILTER_CYC = (WAKE_FILTER_US * 1000000) / CLOCK_PERIOD_PS;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_US * 1000000) / CLOCK_PERIOD_PS;
	localparam int IRQ_GAP_CYC = (IRQ_GAP_US * 1000000) / CLOCK_PERIOD_PS;
	// Bias select encodings
	localparam logic [1:0] BIAS_NONE = 2'h0;
	localparam logic [1:0] BIAS_PULL_DOWN = 2'h1;
	localparam logic [1:0] BIAS_PULL_UP = 2'h2;
	localparam logic [1:0] BIAS_AUTO = 2'h3;
	// Reset value of the bias select field
	localparam logic [1:0] BIAS_RESET = 2'h0;
	// Operating mode of the chip
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_STOP,
		MODE_SLEEP,
		MODE_FAIL_SAFE,
		MODE_RESTART
	} op_mode_t;
endpackage
`default_nettype wire

/* rtl/wake_filter.sv */
// Purpose: Synchronise the wake pin and accept a level only once it has held.
// Assumes: The pin is asynchronous to clock.
// Notes: The first synchroniser stage feeds only the second.
`default_nettype none
module wake_filter #(
	parameter int FILTER_CYC = 2000 // Cycles a new level must persist
) (
	input wire logic clock, // System clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic pin_async, // Raw pin level
	output logic raw_level, // Synchronised level, no filtering
	output logic filt_level, // Filtered level
	output logic filt_edge // One-cycle pulse on each accepted change
);
	localparam int CW = $clog2(FILTER_CYC + 1);
	// Three-stage synchroniser
	logic s1_q, s2_q, s3_q;
	// Persistence counter
	logic [CW-1:0] cnt_q;
	logic filt_q, edge_q;
	// Stable once second and third stage agree
	wire stable = (s2_q == s3_q);
	wire differs = stable && (s3_q != filt_q);
	wire done = differs && (cnt_q == CW'(FILTER_CYC - 1));

	// Synchroniser chain
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Count how long a differing level has held; any bounce restarts it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			filt_q <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			edge_q <= done;
			if (done) begin
				filt_q <= s3_q;
				cnt_q <= '0;
			end else if (differs) begin
				cnt_q <= cnt_q + CW'(1);
			end else begin
				cnt_q <= '0;
			end
		end
	end

	assign raw_level = s3_q;
	assign filt_level = filt_q;
	assign filt_edge = edge_q;

	// A new level is taken only after it held the full filter time
	filter_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(edge_q) |-> $past(s3_q, 2) == filt_q)
		else $error("filtered level not taken from pin");
endmodule // wake_filter
`default_nettype wire

/* rtl/wake_irq.sv */
// How it works
// - Every pin edge makes a wake event.
// - Interrupt in normal/stop, wake in sleep/fail-safe.
// - Fail-safe pin edge always requests restart.
// - Stop-mode modulation follows pin when selected.
// - Modulation select uses unfiltered pin level.
// - Static or cyclic sensing selectable.
// - Edge accepted after filter time persists.
// - Enable bit gates wake and interrupt.
// - Pin level readable in normal/stop.
// - Pin wake sets pin event flag.
// - Two-bit bias field encodes four modes.
// - Auto bias follows detected pin level.
// - Interrupt low for pulse time, then high.
// - Gap high time between interrupt pulses.
// - Pulse and gap both typically 100 us.
// - Interrupt never changes operating mode.
// - Status events interrupt only if enabled.
// - Level status never interrupts nor latches.
// - Entering stop with flags pending interrupts.
// - Stop-mode PFM to PWM switch interrupts.
// - Status registers update at pulse fall.
// - Events stay latched until cleared.
// Purpose: Wake pin input and interrupt pulse generator.
// Assumes: Mode and status clears come from the chip's control logic.
// Notes: Status visible to software takes new events only at interrupt pulse start; clears apply at once.
`default_nettype none
module wake_irq
	import wake_pkg::*;
#(
	parameter int FILTER_CYC = WAKE_FILTER_CYC, // Wake filter cycles
	parameter int PULSE_CYC = IRQ_PULSE_CYC, // Interrupt low cycles
	parameter int GAP_CYC = IRQ_GAP_CYC // Minimum high cycles
) (
	input wire logic clock, // 125 MHz system clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic hv_wake_pin, // Wake pin comparator output
	input wire wake_pkg::op_mode_t op_mode, // Current operating mode
	input wire logic wake_pin_enable, // Pin acts as wake source
	input wire logic cyclic_sense, // 1 selects cyclic sensing
	input wire logic cyclic_window, // Cyclic sense window open
	input wire logic stop_modulation_by_pin, // Pin picks modulation in stop
	input wire logic [1:0] wake_bias_control, // Bias select high/low
	input wire logic [7:0] other_events, // Other wake events, one-cycle pulses
	input wire logic [7:0] other_enables, // Wake enables for other events
	input wire logic stop_entry, // Pulse: commanded into stop mode
	input wire logic pfm_to_pwm, // Pulse: buck switched PFM to PWM
	input wire logic clear_first, // Pulse: clear first status register
	input wire logic clear_second, // Pulse: clear second status register
	output logic irq_n, // Interrupt output, active low
	output logic wake_request, // Pulse: wake chip from sleep
	output logic restart_request, // Pulse: fail-safe to restart
	output logic modulation_pwm, // 1 selects PWM in stop
	output logic pull_up_en, // Pin pull-up current on
	output logic pull_down_en, // Pin pull-down current on
	output logic wake_level_status, // Pin level, normal and stop
	output logic wake_pin_event_flag, // Visible first status: pin wake
	output logic [7:0] wake_status_second // Visible second status
);
	import wake_pkg::*;

	localparam int CW = $clog2((PULSE_CYC > GAP_CYC ? PULSE_CYC : GAP_CYC) + 1);

	// Interrupt sequencer states
	typedef enum logic [1:0] {
		IRQ_IDLE,
		IRQ_LOW,
		IRQ_GAP
	} irq_state_t;

	logic raw_level, filt_level, filt_edge;
	irq_state_t state_q, state_d;
	logic [CW-1:0] cnt_q;
	logic pend_q; // Interrupt waiting for the sequencer
	logic pin_flag_q; // Latched pin event, internal
	logic [7:0] second_q; // Latched other events, internal
	logic irq_n_q, wake_q, restart_q, pwm_q, pu_q, pd_q, lvl_q, vis_pin_q;
	logic [7:0] vis_second_q;

	wake_filter #(
		.FILTER_CYC(FILTER_CYC)
	) u_filter (
		.clock(clock),
		.reset_n(reset_n),
		.pin_async(hv_wake_pin),
		.raw_level(raw_level),
		.filt_level(filt_level),
		.filt_edge(filt_edge)
	);

	// Mode decode
	wire mode_run = (op_mode == MODE_NORMAL) || (op_mode == MODE_STOP);
	wire mode_stop = (op_mode == MODE_STOP);
	wire mode_sleep = (op_mode == MODE_SLEEP);
	wire mode_fs = (op_mode == MODE_FAIL_SAFE);
	// Cyclic sensing only listens inside its window
	wire sense_open = !cyclic_sense || cyclic_window;
	wire pin_edge = filt_edge && sense_open;
	// Pin used as modulation select gets no wake role in stop
	wire pin_is_mod = mode_stop && stop_modulation_by_pin;
	wire pin_event = pin_edge && wake_pin_enable && !pin_is_mod;
	wire pin_irq_ev = pin_event && mode_run;
	wire pin_wake_ev = pin_event && mode_sleep;
	wire fs_restart = pin_edge && mode_fs;
	wire [7:0] other_live = other_events & other_enables;
	wire any_flag = pin_flag_q || (|second_q);
	wire stop_pending = stop_entry && any_flag;
	wire buck_irq = pfm_to_pwm && mode_stop;
	// Status events raise interrupts only in normal and stop
	wire irq_cause = pin_irq_ev || (mode_run && (|other_live)) || stop_pending || buck_irq;
	wire pulse_done = (state_q == IRQ_LOW) && (cnt_q == CW'(PULSE_CYC - 1));
	wire gap_done = (state_q == IRQ_GAP) && (cnt_q == CW'(GAP_CYC - 1));
	wire pulse_start = (state_q == IRQ_IDLE) && (pend_q || irq_cause);
	// Auto bias follows the filtered level
	wire bias_up = (wake_bias_control == BIAS_PULL_UP) ||
		((wake_bias_control == BIAS_AUTO) && filt_level);
	wire bias_down = (wake_bias_control == BIAS_PULL_DOWN) ||
		((wake_bias_control == BIAS_AUTO) && !filt_level);

	// Sequencer next state; a cause during low or gap waits as pending
	always_comb begin
		state_d = state_q;
		case (state_q)
			IRQ_IDLE: begin
				if (pend_q || irq_cause)
					state_d = IRQ_LOW;
			end
			IRQ_LOW: begin
				if (pulse_done)
					state_d = IRQ_GAP;
			end
			IRQ_GAP: begin
				if (gap_done)
					state_d = IRQ_IDLE;
			end
			default: state_d = IRQ_IDLE;
		endcase
	end

	// Sequencer and pulse timing counter
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= IRQ_IDLE;
			cnt_q <= '0;
			pend_q <= 1'b0;
			irq_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_d != state_q) ? '0 : cnt_q + CW'(1);
			// Cause arriving while busy is kept for the next pulse
			pend_q <= (state_q != IRQ_IDLE) && (pend_q || irq_cause);
			irq_n_q <= (state_d != IRQ_LOW);
		end
	end

	// Latched events: set wins over clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_flag_q <= 1'b0;
			second_q <= 8'h00;
		end else begin
			pin_flag_q <= pin_event && (mode_run || mode_sleep) ||
				(pin_flag_q && !clear_first);
			second_q <= other_live | (second_q & {8{!clear_second}});
		end
	end

	// Visible status copies, refreshed at each falling interrupt edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			vis_pin_q <= 1'b0;
			vis_second_q <= 8'h00;
		end else if (pulse_start) begin
			// Same values the latched copies take at this edge, clears included
			vis_pin_q <= (pin_flag_q && !clear_first) || pin_irq_ev;
			vis_second_q <= (second_q & {8{!clear_second}}) | other_live;
		end else begin
			// Clears still reach software without an interrupt
			vis_pin_q <= vis_pin_q && !clear_first;
			vis_second_q <= vis_second_q & {8{!clear_second}};
		end
	end

	// Wake requests, bias, modulation and level; none of these touch the mode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wake_q <= 1'b0;
			restart_q <= 1'b0;
			pwm_q <= 1'b0;
			pu_q <= 1'b0;
			pd_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			wake_q <= pin_wake_ev;
			restart_q <= fs_restart;
			// Unfiltered level: the controller drives the pin firmly
			if (pin_is_mod)
				pwm_q <= raw_level;
			pu_q <= bias_up;
			pd_q <= bias_down;
			// Plain level, never latched and never an interrupt source
			if (mode_run)
				lvl_q <= filt_level;
		end
	end

	assign irq_n = irq_n_q;
	assign wake_request = wake_q;
	assign restart_request = restart_q;
	assign modulation_pwm = pwm_q;
	assign pull_up_en = pu_q;
	assign pull_down_en = pd_q;
	assign wake_level_status = lvl_q;
	assign wake_pin_event_flag = vis_pin_q;
	assign wake_status_second = vis_second_q;

	// Pulse and gap spans are checked over 8 cycles; keep both counts at 8 or more
	sequence low_pulse_s;
		!irq_n_q [*8];
	endsequence

	sequence gap_high_s;
		irq_n_q [*8];
	endsequence

	// Interrupt timing
	irq_low_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(irq_n_q) |-> low_pulse_s)
		else $error("interrupt pulse too short");
	irq_gap_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(irq_n_q) |-> gap_high_s)
		else $error("interrupt gap too short");
	// A cause while busy must survive until the gap is over
	pend_kept_a: assert property (@(posedge clock) disable iff (!reset_n)
		(irq_cause && state_q != IRQ_IDLE) |=> pend_q)
		else $error("busy cause not kept pending");
	// With nothing to report the output stays released
	irq_idle_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
		(state_q == IRQ_IDLE && !pend_q && !irq_cause) |=> irq_n_q)
		else $error("interrupt without a cause");

	// Interrupt sources; a busy sequencer keeps the cause pending instead
	pin_irq_fire_a: assert property (@(posedge clock) disable iff (!reset_n)
		(pin_irq_ev && state_q == IRQ_IDLE) |=> !irq_n_q)
		else $error("pin event did not interrupt");
	buck_irq_a: assert property (@(posedge clock) disable iff (!reset_n)
		buck_irq |=> (!irq_n_q || pend_q))
		else $error("buck switch did not interrupt");
	stop_pend_a: assert property (@(posedge clock) disable iff (!reset_n)
		(stop_entry && any_flag) |=> (pend_q || state_q != IRQ_IDLE))
		else $error("stop entry with flags did not interrupt");

	// Wake and restart requests
	sleep_wake_a: assert property (@(posedge clock) disable iff (!reset_n)
		pin_wake_ev |=> wake_q)
		else $error("pin edge did not wake from sleep");
	// One accepted edge gives one request, never a stretched one
	wake_single_a: assert property (@(posedge clock) disable iff (!reset_n)
		wake_q |=> !wake_q)
		else $error("wake request longer than one cycle");
	fs_restart_a: assert property (@(posedge clock) disable iff (!reset_n)
		(filt_edge && sense_open && mode_fs) |=> restart_q)
		else $error("fail-safe edge did not request restart");
	enable_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
		!wake_pin_enable |=> !wake_q)
		else $error("wake without enable");
	// Requests come from pin edges alone, never from an interrupt
	mode_source_a: assert property (@(posedge clock) disable iff (!reset_n)
		(wake_q || restart_q) |-> $past(pin_edge))
		else $error("mode request without a pin edge");

	// Bias, modulation and level
	auto_bias_a: assert property (@(posedge clock) disable iff (!reset_n)
		(wake_bias_control == BIAS_AUTO) |=> (pu_q != pd_q))
		else $error("auto bias not exclusive");
	bias_none_a: assert property (@(posedge clock) disable iff (!reset_n)
		(wake_bias_control == BIAS_NONE) |=> (!pu_q && !pd_q))
		else $error("bias current on while none selected");
	// Outside by-pin stop the last modulation choice is kept
	mod_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		!pin_is_mod |=> $stable(pwm_q))
		else $error("modulation changed outside by-pin stop");
	// Modulation copies the raw level one cycle later, with no filter delay
	mod_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
		pin_is_mod |=> (pwm_q == $past(raw_level)))
		else $error("modulation not following raw pin level");
	level_freeze_a: assert property (@(posedge clock) disable iff (!reset_n)
		!mode_run |=> $stable(lvl_q))
		else $error("level status moved outside normal or stop");

	// Latched and visible status
	flag_set_a: assert property (@(posedge clock) disable iff (!reset_n)
		(pin_event && mode_run) |=> pin_flag_q)
		else $error("pin event not latched");
	flag_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		(pin_flag_q && !clear_first) |=> pin_flag_q)
		else $error("pin flag lost without clear");
	second_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		!clear_second |=> ((second_q & $past(second_q)) == $past(second_q)))
		else $error("second status bit lost without clear");
	// Software sees new status only when a pulse starts, or loses it on a clear
	status_refresh_a: assert property (@(posedge clock) disable iff (!reset_n)
		(vis_second_q != $past(vis_second_q)) |->
			($fell(irq_n_q) || $past(clear_second)))
		else $error("visible status changed outside pulse start");
endmodule // wake_irq
`default_nettype wire

/* tb/mcu_model.sv */
// Purpose: Microcontroller side that reads and clears status after each interrupt.
// Assumes: Status is cleared on the cycle after the interrupt output rises.
// Notes: Clearing can be held off so that flags stay pending.
`default_nettype none
module mcu_model (
	input wire logic clock, // System clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic irq_n, // Interrupt from the block
	input wire logic auto_clear, // 1 lets the model clear status
	output logic clear_first, // Pulse: clear first status
	output logic clear_second // Pulse: clear second status
);
	timeunit 1ns;
	timeprecision 1ps;
	logic irq_q; // Last interrupt level, finds the release edge
	// Clear both registers once the pulse is over, as software would
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b1;
			clear_first <= 1'b0;
			clear_second <= 1'b0;
		end else begin
			irq_q <= irq_n;
			clear_first <= auto_clear & irq_n & ~irq_q;
			clear_second <= auto_clear & irq_n & ~irq_q;
		end
	end
endmodule // mcu_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the wake input and interrupt block.
// Assumes: Short filter, pulse and gap counts so the run stays brief.
// Notes: Outputs are sampled on the falling clock edge, away from updates.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import wake_pkg::*;
	localparam int FC = 4; // Filter cycles
	localparam int PC = 8; // Pulse cycles
	localparam int GC = 8; // Gap cycles
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic pin = 1'b0; // Always a defined level
	logic en = 1'b0, cs = 1'b0, cw = 1'b0, byp = 1'b0, se = 1'b0, p2p = 1'b0, ac = 1'b1;
	logic [1:0] bias = 2'h0; // Bias select
	logic [7:0] oev = 8'h00, oen = 8'h00; // Other events and enables
	op_mode_t mode = MODE_NORMAL; // Operating mode
	logic cf, cl2, irq_n, wreq, rreq, mpwm, pu, pd, wls, wflag, fl;
	logic [7:0] ws2, s2; // Second status, and its copy at pulse start
	int bad_count = 0, total_checks = 0, cycles = 0, h, w, r, q;
	wake_irq #(.FILTER_CYC(FC), .PULSE_CYC(PC), .GAP_CYC(GC)) uut (
		.clock(clock), .reset_n(reset_n), .hv_wake_pin(pin), .op_mode(mode),
		.wake_pin_enable(en), .cyclic_sense(cs), .cyclic_window(cw),
		.stop_modulation_by_pin(byp), .wake_bias_control(bias), .other_events(oev),
		.other_enables(oen), .stop_entry(se), .pfm_to_pwm(p2p), .clear_first(cf),
		.clear_second(cl2), .irq_n(irq_n), .wake_request(wreq), .restart_request(rreq),
		.modulation_pwm(mpwm), .pull_up_en(pu), .pull_down_en(pd),
		.wake_level_status(wls), .wake_pin_event_flag(wflag), .wake_status_second(ws2)
	);
	mcu_model partner (
		.clock(clock), .reset_n(reset_n), .irq_n(irq_n), .auto_clear(ac),
		.clear_first(cf), .clear_second(cl2)
	);
	// Free-running 125 MHz clock
	always #4 clock = ~clock;
	// Hang guard: well above the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Wait for a pulse or its absence; hi returns cycles spent high first
	task wait_low(input logic exp, output int hi);
		int lo;
		hi = 0;
		lo = 0;
		while (irq_n !== 1'b0 && hi < 60) begin
			@(negedge clock);
			hi++;
		end
		check({7'h0, ~irq_n}, {7'h0, exp});
		fl = wflag;
		s2 = ws2;
		if (irq_n === 1'b0) begin
			while (irq_n === 1'b0 && lo < 60) begin
				@(negedge clock);
				lo++;
			end
			check(lo[7:0], PC[7:0]);
		end
	endtask
	// Count request pulses and interrupt cycles over a fixed span
	task watch(output int wc, output int rc, output int qc);
		wc = 0;
		rc = 0;
		qc = 0;
		repeat (40) begin
			@(negedge clock);
			wc += int'(wreq === 1'b1);
			rc += int'(rreq === 1'b1);
			qc += int'(irq_n === 1'b0);
		end
	endtask
	task ev(input logic [7:0] b);
		@(posedge clock) oev <= b;
		@(posedge clock) oev <= 8'h00;
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		check({irq_n, wreq, rreq, mpwm, pu, pd, wls, wflag}, 8'h80);
		// Disabled pin: level still visible, no pulse
		@(posedge clock) pin <= 1'b1;
		wait_low(1'b0, h);
		check({7'h0, wls}, 8'h01);
		// Both edges interrupt; the first marks the pin as source, then the flag clears
		@(posedge clock) begin en <= 1'b1; pin <= 1'b0; end
		wait_low(1'b1, h);
		check({7'h0, 1'(h > FC + 2)}, 8'h01);
		check({7'h0, fl}, 8'h01);
		@(posedge clock) pin <= 1'b1;
		wait_low(1'b1, h);
		repeat (2) @(negedge clock);
		check({7'h0, wflag}, 8'h00);
		// Cyclic sensing drops edges outside the window
		@(posedge clock) begin cs <= 1'b1; pin <= 1'b0; end
		wait_low(1'b0, h);
		@(posedge clock) begin cw <= 1'b1; pin <= 1'b1; end
		wait_low(1'b1, h);
		@(posedge clock) begin cs <= 1'b0; cw <= 1'b0; end
		// Other sources only interrupt when enabled
		ev(8'h04);
		wait_low(1'b0, h);
		@(posedge clock) begin oen <= 8'h04; ac <= 1'b0; end
		ev(8'h04);
		wait_low(1'b1, h);
		check(s2, 8'h04);
		// Entering stop with flags pending, inside the gap
		@(posedge clock) begin mode <= MODE_STOP; se <= 1'b1; end
		@(posedge clock) se <= 1'b0;
		wait_low(1'b1, h);
		check({7'h0, 1'(h >= GC)}, 8'h01);
		check(s2, 8'h04);
		// Buck switching to PWM in stop
		ac <= 1'b1;
		@(posedge clock) p2p <= 1'b1;
		@(posedge clock) p2p <= 1'b0;
		wait_low(1'b1, h);
		// Pin selects modulation, unfiltered, without interrupts
		@(posedge clock) begin byp <= 1'b1; pin <= 1'b0; end
		wait_low(1'b0, h);
		@(posedge clock) pin <= 1'b1;
		repeat (5) @(posedge clock);
		@(negedge clock) check({7'h0, mpwm}, 8'h01);
		@(posedge clock) pin <= 1'b0;
		repeat (5) @(posedge clock);
		@(negedge clock) check({7'h0, mpwm}, 8'h00);
		// Let the filter settle while the pin still selects modulation
		repeat (20) @(posedge clock);
		// Sleep wakes, fail-safe restarts even when disabled
		@(posedge clock) begin byp <= 1'b0; mode <= MODE_SLEEP; pin <= 1'b1; end
		watch(w, r, q);
		check({w[3:0], r[1:0], q[1:0]}, 8'h10);
		@(posedge clock) begin en <= 1'b0; mode <= MODE_FAIL_SAFE; pin <= 1'b0; end
		watch(w, r, q);
		check({w[3:0], r[1:0], q[1:0]}, 8'h04);
		// Every bias code at both pin levels
		@(posedge clock) mode <= MODE_NORMAL;
		for (int lv = 0; lv < 2; lv++) begin
			@(posedge clock) pin <= lv[0];
			repeat (20) @(posedge clock);
			for (int c = 0; c < 4; c++) begin
				@(posedge clock) bias <= c[1:0];
				repeat (3) @(negedge clock);
				check({6'h0, pu, pd}, {6'h0, c == 2 || (c == 3 && lv == 1),
					c == 1 || (c == 3 && lv == 0)});
			end
		end
		end_sim();
	end
endmodule // tb
`default_nettype wire
